/* hdl/thr_cmp_pkg.sv */
// Purpose: Shared constants for the error threshold compare block.
// Assumes: Byte-wide register port with an 8-bit address.
// Notes:   Offsets are used by the top module and the bench, field positions by the top module only.

package thr_cmp_pkg;

    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int VAL_W  = 16;
    localparam int MODE_W = 3;
    localparam int TRIG_W = 5;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CALC_ERROR_LOW       = 8'h00;
    localparam logic [7:0] OFS_CALC_ERROR_HIGH      = 8'h01;
    localparam logic [7:0] OFS_LOWER_LIMIT_LOW      = 8'h02;
    localparam logic [7:0] OFS_LOWER_LIMIT_HIGH     = 8'h03;
    localparam logic [7:0] OFS_UPPER_LIMIT_LOW      = 8'h04;
    localparam logic [7:0] OFS_UPPER_LIMIT_HIGH     = 8'h05;
    localparam logic [7:0] OFS_AUTO_TRIGGER_SOURCE  = 8'h06;
    localparam logic [7:0] OFS_CONVERTER_CONTROL_3  = 8'h07;
    localparam logic [7:0] OFS_CONVERTER_STATUS     = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS           = 8'h09;
    localparam logic [7:0] OFS_IRQ_MASK             = 8'h0A;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int POS_TRIG_LSB      = 0;
    localparam int POS_IRQ_MODE_LSB  = 0;
    localparam int POS_CALC_MODE_LSB = 4;
    localparam int POS_ABOVE_UPPER   = 6;
    localparam int POS_BELOW_LOWER   = 5;
    localparam int POS_IRQ_THRESHOLD = 0;
    localparam int IRQ_BITS          = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] RST_TRIG      = 5'h00;
    localparam logic [2:0] RST_IRQ_MODE  = 3'h0;
    localparam logic [2:0] RST_CALC_MODE = 3'h0;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [0:0] RST_IRQ       = 1'h0;

    // ------------------------------------------------------------------
    // Threshold interrupt modes
    // ------------------------------------------------------------------
    localparam logic [2:0] TMD_NEVER        = 3'h0;
    localparam logic [2:0] TMD_BELOW_LOWER  = 3'h1;
    localparam logic [2:0] TMD_NOT_BELOW    = 3'h2;
    localparam logic [2:0] TMD_INSIDE       = 3'h3;
    localparam logic [2:0] TMD_OUTSIDE      = 3'h4;
    localparam logic [2:0] TMD_NOT_ABOVE    = 3'h5;
    localparam logic [2:0] TMD_ABOVE_UPPER  = 3'h6;
    localparam logic [2:0] TMD_ALWAYS       = 3'h7;

endpackage

/* hdl/thr_window_compare.sv */
// Purpose: Signed window comparison of the error value and mode selection.
// Assumes: All inputs are stable register or same-clock values.
// Notes:   Purely combinational; the top module registers every result.

`timescale 1ns/10ps

module thr_window_compare (
    input  wire logic [15:0] error_i,
    input  wire logic [15:0] lower_i,
    input  wire logic [15:0] upper_i,
    input  wire logic [2:0]  mode_i,
    output logic             above_o,
    output logic             below_o,
    output logic             hit_o
);
    import thr_cmp_pkg::*;

    // ------------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------------
    // Signed compare so that negative errors fall below a positive limit.
    always_comb begin
        above_o = $signed(error_i) > $signed(upper_i);
        below_o = $signed(error_i) < $signed(lower_i);
    end

    // ------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------
    always_comb begin
        case (mode_i)
            TMD_NEVER:       hit_o = 1'b0;
            TMD_BELOW_LOWER: hit_o = below_o;
            TMD_NOT_BELOW:   hit_o = !below_o;
            TMD_INSIDE:      hit_o = !below_o && !above_o;
            TMD_OUTSIDE:     hit_o = below_o || above_o;
            TMD_NOT_ABOVE:   hit_o = !above_o;
            TMD_ABOVE_UPPER: hit_o = above_o;
            TMD_ALWAYS:      hit_o = 1'b1;
            default:         hit_o = 1'b0;
        endcase
    end

endmodule

/* hdl/adc_error_threshold_compare.sv */
// Purpose: Threshold compare and trigger select registers of a converter unit.
// Assumes: Error value and its done strobe come from logic on REF_CLK_I.
// Notes:   Byte registers on a plain strobe port, read data one cycle later.
//
// Implementation choices: strobed register access and the register addresses.

`timescale 1ns/10ps

module adc_error_threshold_compare (
    input  wire logic                           REF_CLK_I,
    input  wire logic                           RESET_I,
    input  wire logic                           CE_I,
    input  wire logic [thr_cmp_pkg::ADDR_W-1:0] ADDR_I,
    input  wire logic [thr_cmp_pkg::DATA_W-1:0] WDATA_I,
    input  wire logic                           WR_I,
    input  wire logic                           RD_I,
    output logic      [thr_cmp_pkg::DATA_W-1:0] RDATA_O,
    input  wire logic [thr_cmp_pkg::VAL_W-1:0]  CALC_ERROR_I,
    input  wire logic                           CALC_DONE_I,
    output logic      [thr_cmp_pkg::MODE_W-1:0] CALC_MODE_O,
    output logic      [thr_cmp_pkg::TRIG_W-1:0] TRIGGER_SEL_O,
    output logic                                ABOVE_UPPER_O,
    output logic                                BELOW_LOWER_O,
    output logic                                IRQ_O
);
    import thr_cmp_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [15:0]         calc_error_value;
    logic [15:0]         lower_limit_value;
    logic [15:0]         upper_limit_value;
    logic [4:0]          auto_trigger_select;
    logic [2:0]          threshold_irq_mode;
    logic [2:0]          calc_mode_select;
    logic                above_upper_flag;
    logic                below_lower_flag;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] irq_event;
    logic [IRQ_BITS-1:0] irq_clear;
    logic [7:0]          next_rdata;
    logic                cmp_above;
    logic                cmp_below;
    logic                cmp_hit;
    logic                wr_en;
    logic                rd_en;

    assign wr_en = WR_I && CE_I;
    assign rd_en = RD_I && CE_I;

    // ------------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------------
    thr_window_compare u_compare (
        .error_i (CALC_ERROR_I),
        .lower_i (lower_limit_value),
        .upper_i (upper_limit_value),
        .mode_i  (threshold_irq_mode),
        .above_o (cmp_above),
        .below_o (cmp_below),
        .hit_o   (cmp_hit)
    );

    // ------------------------------------------------------------------
    // Error capture
    // ------------------------------------------------------------------
    // Captured with the flags so a read always matches the flags shown.
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            calc_error_value <= {RST_BYTE, RST_BYTE};
        end else if (CE_I && CALC_DONE_I) begin
            calc_error_value <= CALC_ERROR_I;
        end
    end

    // ------------------------------------------------------------------
    // Limit registers
    // ------------------------------------------------------------------
    // No reset on the limits: software must load them before enabling.
    always_ff @(posedge REF_CLK_I) begin
        if (wr_en) begin
            case (ADDR_I)
                OFS_LOWER_LIMIT_LOW:  lower_limit_value[7:0]  <= WDATA_I;
                OFS_LOWER_LIMIT_HIGH: lower_limit_value[15:8] <= WDATA_I;
                OFS_UPPER_LIMIT_LOW:  upper_limit_value[7:0]  <= WDATA_I;
                OFS_UPPER_LIMIT_HIGH: upper_limit_value[15:8] <= WDATA_I;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Trigger select
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            auto_trigger_select <= RST_TRIG;
        end else if (wr_en && ADDR_I == OFS_AUTO_TRIGGER_SOURCE) begin
            auto_trigger_select <= WDATA_I[POS_TRIG_LSB +: TRIG_W];
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            threshold_irq_mode <= RST_IRQ_MODE;
            calc_mode_select   <= RST_CALC_MODE;
        end else if (wr_en && ADDR_I == OFS_CONVERTER_CONTROL_3) begin
            threshold_irq_mode <= WDATA_I[POS_IRQ_MODE_LSB +: MODE_W];
            calc_mode_select   <= WDATA_I[POS_CALC_MODE_LSB +: MODE_W];
        end
    end

    // ------------------------------------------------------------------
    // Threshold flags
    // ------------------------------------------------------------------
    // Flags reflect the most recent comparison only, so they are not sticky.
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            above_upper_flag <= 1'b0;
            below_lower_flag <= 1'b0;
        end else if (CE_I && CALC_DONE_I) begin
            above_upper_flag <= cmp_above;
            below_lower_flag <= cmp_below;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    assign irq_event[POS_IRQ_THRESHOLD] = CALC_DONE_I && cmp_hit;
    assign irq_clear = (wr_en && ADDR_I == OFS_IRQ_STATUS) ? WDATA_I[IRQ_BITS-1:0] : '0;

    // A new event in the cycle of a clear keeps its bit set.
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            irq_status <= RST_IRQ;
        end else if (CE_I) begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            irq_mask <= RST_IRQ;
        end else if (wr_en && ADDR_I == OFS_IRQ_MASK) begin
            irq_mask <= WDATA_I[IRQ_BITS-1:0];
        end
    end

    // Registered output uses the next status value, so it changes in the same cycle as the status bit.
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            IRQ_O <= 1'b0;
        end else if (CE_I) begin
            IRQ_O <= |(((irq_status & ~irq_clear) | irq_event) & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = RST_BYTE;
        case (ADDR_I)
            OFS_CALC_ERROR_LOW:      next_rdata = calc_error_value[7:0];
            OFS_CALC_ERROR_HIGH:     next_rdata = calc_error_value[15:8];
            OFS_LOWER_LIMIT_LOW:     next_rdata = lower_limit_value[7:0];
            OFS_LOWER_LIMIT_HIGH:    next_rdata = lower_limit_value[15:8];
            OFS_UPPER_LIMIT_LOW:     next_rdata = upper_limit_value[7:0];
            OFS_UPPER_LIMIT_HIGH:    next_rdata = upper_limit_value[15:8];
            OFS_AUTO_TRIGGER_SOURCE: next_rdata = {3'h0, auto_trigger_select};
            OFS_CONVERTER_CONTROL_3: begin
                next_rdata[POS_IRQ_MODE_LSB +: MODE_W]  = threshold_irq_mode;
                next_rdata[POS_CALC_MODE_LSB +: MODE_W] = calc_mode_select;
            end
            OFS_CONVERTER_STATUS: begin
                next_rdata[POS_ABOVE_UPPER] = above_upper_flag;
                next_rdata[POS_BELOW_LOWER] = below_lower_flag;
            end
            OFS_IRQ_STATUS:          next_rdata[IRQ_BITS-1:0] = irq_status;
            OFS_IRQ_MASK:            next_rdata[IRQ_BITS-1:0] = irq_mask;
            default:                 next_rdata = RST_BYTE;
        endcase
    end

    // Data stand only in the cycle after the read strobe.
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            RDATA_O <= RST_BYTE;
        end else if (CE_I) begin
            RDATA_O <= rd_en ? next_rdata : RST_BYTE;
        end
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            CALC_MODE_O   <= RST_CALC_MODE;
            TRIGGER_SEL_O <= RST_TRIG;
            ABOVE_UPPER_O <= 1'b0;
            BELOW_LOWER_O <= 1'b0;
        end else if (CE_I) begin
            CALC_MODE_O   <= calc_mode_select;
            TRIGGER_SEL_O <= auto_trigger_select;
            ABOVE_UPPER_O <= above_upper_flag;
            BELOW_LOWER_O <= below_lower_flag;
        end
    end

endmodule

/* tb/thr_cmp_properties.sv */
// Purpose: Port level checks of the error threshold compare block.
// Assumes: Only the top module ports are visible; CE_I stays high in the bench.
// Notes:   The limits are internal, so flag values are left to the bench.
`timescale 1ns/10ps

module thr_cmp_properties
    import thr_cmp_pkg::*;
(
    input wire logic              REF_CLK_I,
    input wire logic              RESET_I,
    input wire logic              CE_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WDATA_I,
    input wire logic              WR_I,
    input wire logic              RD_I,
    input wire logic [DATA_W-1:0] RDATA_O,
    input wire logic [VAL_W-1:0]  CALC_ERROR_I,
    input wire logic              CALC_DONE_I,
    input wire logic [MODE_W-1:0] CALC_MODE_O,
    input wire logic [TRIG_W-1:0] TRIGGER_SEL_O,
    input wire logic              ABOVE_UPPER_O,
    input wire logic              IRQ_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);

    AST_TRIG_HI_ZERO: assert property (RD_I && CE_I && ADDR_I == OFS_AUTO_TRIGGER_SOURCE
        |=> RDATA_O[7:5] == 3'h0) else $error("trigger upper bits not zero");
    AST_TRIG_FOLLOW: assert property (WR_I && CE_I && ADDR_I == OFS_AUTO_TRIGGER_SOURCE
        |-> ##2 TRIGGER_SEL_O == 5'($past(WDATA_I, 2))) else $error("trigger select wrong");
    AST_MODE_FOLLOW: assert property (WR_I && CE_I && ADDR_I == OFS_CONVERTER_CONTROL_3
        |-> ##2 CALC_MODE_O == 3'($past(WDATA_I, 2) >> 4)) else $error("calc mode wrong");
    AST_TRIG_RESET: assert property ($past(RESET_I) |-> TRIGGER_SEL_O == 5'h00)
        else $error("trigger select not cleared");
    AST_FLAG_HOLD: assert property (CE_I && !$past(CALC_DONE_I, 2) |-> $stable(ABOVE_UPPER_O))
        else $error("above flag moved without compare");
    AST_IRQ_CAUSE: assert property ($rose(IRQ_O) |-> $past(CALC_DONE_I) || $past(WR_I)
        || $past(WR_I, 2)) else $error("interrupt rose without cause");
    AST_IRQ_DROP: assert property ($fell(IRQ_O) |-> $past(WR_I) || $past(WR_I, 2))
        else $error("interrupt fell without a write");
    AST_ERR_LOW: assert property (CALC_DONE_I ##1 !CALC_DONE_I ##1
        (RD_I && ADDR_I == OFS_CALC_ERROR_LOW) |=> RDATA_O == 8'($past(CALC_ERROR_I, 3)))
        else $error("error low byte wrong");
endmodule

bind adc_error_threshold_compare thr_cmp_properties thr_cmp_properties_inst (
    .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .CALC_ERROR_I(CALC_ERROR_I), .CALC_DONE_I(CALC_DONE_I), .CALC_MODE_O(CALC_MODE_O),
    .TRIGGER_SEL_O(TRIGGER_SEL_O), .ABOVE_UPPER_O(ABOVE_UPPER_O), .IRQ_O(IRQ_O));

/* tb/adc_error_threshold_compare_tb_top.sv */
// Purpose: Register level tests of the error threshold compare block.
// Assumes: Clock enable held high; the bench acts as bus master.
// Notes:   Expected flags come from a signed model of the current limits.
`timescale 1ns/10ps

module adc_error_threshold_compare_tb_top;
    import thr_cmp_pkg::*;
    logic        clk, rst, ce, wr, rd, done, above, below, irq;
    logic [7:0]  addr, wdata, rdata, d;
    logic [15:0] err, lo, up;
    logic [2:0]  cmode;
    logic [4:0]  tsel;
    logic [7:0]  tv [3] = '{8'hFF, 8'hE0, 8'h15};
    logic [15:0] ev [5] = '{16'h00C8, 16'hFFF6, 16'h0000, 16'h0064, 16'hFFFB};
    int          err_total, num_checks, m, k;

    adc_error_threshold_compare adc_error_threshold_compare_inst (
        .REF_CLK_I(clk), .RESET_I(rst), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CALC_ERROR_I(err), .CALC_DONE_I(done),
        .CALC_MODE_O(cmode), .TRIGGER_SEL_O(tsel), .ABOVE_UPPER_O(above),
        .BELOW_LOWER_O(below), .IRQ_O(irq));

    function automatic logic [1:0] flg(input logic [15:0] e);
        flg = {$signed(e) > $signed(up), $signed(e) < $signed(lo)};
    endfunction
    function automatic logic hit(input logic [2:0] md, input logic [15:0] e);
        logic [1:0] f;
        f = flg(e);
        case (md)
            TMD_NEVER:       hit = 1'b0;
            TMD_BELOW_LOWER: hit = f[0];
            TMD_NOT_BELOW:   hit = !f[0];
            TMD_INSIDE:      hit = f == 2'b00;
            TMD_OUTSIDE:     hit = f != 2'b00;
            TMD_NOT_ABOVE:   hit = !f[1];
            TMD_ABOVE_UPPER: hit = f[1];
            default:         hit = 1'b1;
        endcase
    endfunction

    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk); wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk); wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk); rd <= 1'b1; addr <= a;
        @(posedge clk); rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic run(input logic [15:0] e);
        @(posedge clk); err <= e; done <= 1'b1;
        @(posedge clk); done <= 1'b0; err <= ~e;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // Whole run is about 700 cycles; 20000 cycles, some thirty times that, means a hang.
    initial begin
        #400000;
        err_total++;
        test_done();
    end

    initial begin
        {rst, ce, wr, rd, done, addr, wdata, err} = {2'b11, 35'h0};
        err_total = 0;
        num_checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFS_AUTO_TRIGGER_SOURCE, d); chk("trig_rst", d, 16'h0000);
        chk("trig_out_rst", tsel, 16'h0000);
        for (k = 0; k < 3; k++) begin
            wr_reg(OFS_AUTO_TRIGGER_SOURCE, tv[k]);
            rd_reg(OFS_AUTO_TRIGGER_SOURCE, d); chk("trig", d, tv[k] & 8'h1F);
            chk("trig_out", tsel, tv[k] & 8'h1F);
        end
        $display("test trigger done");
        lo = 16'hFFFB;
        up = 16'h0064;
        wr_reg(OFS_LOWER_LIMIT_LOW, lo[7:0]); wr_reg(OFS_LOWER_LIMIT_HIGH, lo[15:8]);
        wr_reg(OFS_UPPER_LIMIT_LOW, up[7:0]); wr_reg(OFS_UPPER_LIMIT_HIGH, up[15:8]);
        rd_reg(OFS_LOWER_LIMIT_LOW, d); chk("lo_l", d, lo[7:0]);
        rd_reg(OFS_LOWER_LIMIT_HIGH, d); chk("lo_h", d, lo[15:8]);
        rd_reg(OFS_UPPER_LIMIT_LOW, d); chk("up_l", d, up[7:0]);
        rd_reg(OFS_UPPER_LIMIT_HIGH, d); chk("up_h", d, up[15:8]);
        $display("test limits done");
        wr_reg(OFS_IRQ_MASK, 8'h01);
        for (m = 0; m < 8; m++) begin
            wr_reg(OFS_CONVERTER_CONTROL_3, {1'b0, 3'(m), 1'b0, 3'(m)});
            for (k = 0; k < 5; k++) begin
                if (k == 4) begin
                    up = {8'hFF, up[7:0]};
                    wr_reg(OFS_UPPER_LIMIT_HIGH, up[15:8]);
                end
                run(ev[k]);
                rd_reg(OFS_CALC_ERROR_LOW, d); chk("err_l", d, ev[k][7:0]);
                rd_reg(OFS_CALC_ERROR_HIGH, d); chk("err_h", d, ev[k][15:8]);
                rd_reg(OFS_CONVERTER_STATUS, d); chk("flags", d & 8'h60, {flg(ev[k]), 5'h0});
                chk("flag_out", {above, below}, flg(ev[k]));
                rd_reg(OFS_IRQ_STATUS, d); chk("irq_st", d[0], hit(3'(m), ev[k]));
                chk("irq_out", irq, hit(3'(m), ev[k]));
                wr_reg(OFS_IRQ_STATUS, 8'h01);
                rd_reg(OFS_IRQ_STATUS, d); chk("irq_clr", {d[0], irq}, 16'h0000);
                if (k == 4) begin
                    up = 16'h0064;
                    wr_reg(OFS_UPPER_LIMIT_HIGH, up[15:8]);
                end
            end
            chk("calc_mode", cmode, 16'(m));
        end
        $display("test modes done");
        wr_reg(OFS_IRQ_MASK, 8'h00);
        run(16'h0000);
        rd_reg(OFS_IRQ_STATUS, d); chk("masked_st", d[0], 16'h0001);
        chk("masked_out", irq, 16'h0000);
        wr_reg(OFS_IRQ_MASK, 8'h01);
        rd_reg(OFS_IRQ_MASK, d); chk("unmasked_out", irq, 16'h0001);
        wr_reg(OFS_IRQ_STATUS, 8'h01);
        rd_reg(OFS_IRQ_STATUS, d); chk("cleared_out", irq, 16'h0000);
        $display("test mask done");
        test_done();
    end
endmodule
